// File: logic/fsric_pkg.sv
// constants for the seek, recalibrate and interrupt controller
package fsric_pkg;
  localparam int unsigned CLK_NS = 5;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned MS_CYC = MS_NS / CLK_NS;
  localparam int unsigned STEP_PW_NS = 1000;
  localparam int unsigned STEP_PW_CYC = STEP_PW_NS / CLK_NS;
  localparam logic [7:0] A_SPEC = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_MSR = 8'h08;
  localparam logic [7:0] A_RES = 8'h0c;
  localparam logic [7:0] A_PCN = 8'h10;
  localparam logic [7:0] A_HEAD = 8'h14;
  localparam logic [2:0] OP_SEEK = 3'h1;
  localparam logic [2:0] OP_RECAL = 3'h2;
  localparam logic [2:0] OP_SNSI = 3'h3;
  localparam logic [2:0] OP_SNSD = 3'h4;
  localparam logic [7:0] ST0_NORM = 8'h20;
  localparam logic [7:0] ST0_EC = 8'h70;
  localparam logic [7:0] ST0_NRDY = 8'h68;
  localparam logic [7:0] ST0_RCHG = 8'hc0;
  localparam logic [7:0] ST0_INV = 8'h80;
  localparam logic [6:0] RECAL_MAX = 7'h4d;
  localparam logic [4:0] STEP_BASE = 5'h10;
  localparam logic [7:0] UNLD_STEP = 8'h10;
  localparam logic [7:0] LOAD_STEP = 8'h02;
  localparam logic [15:0] SPEC_RST = 16'h0000;
  typedef enum logic [1:0] {
    FSRIC_IDLE = 2'b00, FSRIC_DEC = 2'b01,
    FSRIC_PULSE = 2'b11, FSRIC_WAIT = 2'b10
  } fsric_step_t;
  typedef enum logic [1:0] {
    FSRIC_H_OFF = 2'b00, FSRIC_H_LOAD = 2'b01,
    FSRIC_H_RDY = 2'b11, FSRIC_H_UNLD = 2'b10
  } fsric_head_t;
endpackage

// File: logic/fsric_top.sv
// head positioning and interrupt reporting of a disk controller
`timescale 1ns/1ps
module fsric_top #(
  parameter int unsigned MS_CYC = fsric_pkg::MS_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [3:0] ready_i,
  input wire logic [3:0] track_zero_i,
  input wire logic [3:0] wprot_i,
  input wire logic result_enter_i,
  input wire logic exec_start_i,
  input wire logic byte_req_i,
  input wire logic host_data_i,
  input wire logic head_req_i,
  input wire logic rw_end_i,
  output logic [3:0] step_o,
  output logic [3:0] dir_o,
  output logic head_load_o,
  output logic head_ready_o,
  output logic dma_mode_o,
  output logic irq_o
);
  if (MS_CYC < 2) begin : g_bad_ms
    $error("MS_CYC too small");
  end

  // bus decode
  logic ack_q;
  wire acc = cyc_i & stb_i & ~ack_q;
  wire wr = acc & we_i;
  wire rd = acc & ~we_i;
  wire wr_spec = wr & (adr_i == fsric_pkg::A_SPEC);
  wire wr_cmd = wr & (adr_i == fsric_pkg::A_CMD) & sel_i[0];
  wire rd_res = rd & (adr_i == fsric_pkg::A_RES);

  // specify register: step[3:0] unload[7:4] load[14:8] nodma[15]
  logic [15:0] spec_q;
  wire [3:0] srt_code = spec_q[3:0];
  wire [3:0] hut_code = spec_q[7:4];
  wire [6:0] hlt_code = spec_q[14:8];
  wire no_dma = spec_q[15];
  assign dma_mode_o = ~no_dma;

  // command fields
  wire [2:0] op = dat_i[2:0];
  wire [1:0] cdrv = dat_i[5:4];
  wire chead = dat_i[6];
  wire [7:0] ctgt = dat_i[15:8];

  // drive side synchronisers
  logic [3:0] rdy_m, rdy_s, rdy_p, tz_m, tz_s, wp_m, wp_s;
  always_ff @(posedge clk_i) begin
    rdy_m <= ready_i;
    rdy_s <= rdy_m;
    tz_m <= track_zero_i;
    tz_s <= tz_m;
    wp_m <= wprot_i;
    wp_s <= wp_m;
  end

  // millisecond tick, scales with the main clock
  logic [31:0] ms_cnt_q;
  wire ms_tick = (ms_cnt_q == 32'(MS_CYC - 1));
  always_ff @(posedge clk_i) begin
    if (rst_i || ms_tick) begin
      ms_cnt_q <= '0;
    end else begin
      ms_cnt_q <= ms_cnt_q + 32'h1;
    end
  end

  // per-drive state
  fsric_pkg::fsric_step_t st_q [4];
  logic [7:0] pcn_q [4];
  logic [7:0] tgt_q [4];
  logic [7:0] code_q [4];
  logic [6:0] nstep_q [4];
  logic [7:0] pw_q [4];
  logic [4:0] iv_q [4];
  logic [3:0] recal_q, dirq, endp_q, busy_q, rchg_q;
  logic [3:0] seek_go, recal_go, sns_clr;
  wire [4:0] step_ms = fsric_pkg::STEP_BASE - {1'b0, srt_code};

  // command acceptance
  logic [3:0] stepping;
  wire any_step = |stepping;
  wire pend = |endp_q | |rchg_q;
  wire is_seek = (op == fsric_pkg::OP_SEEK);
  wire is_recal = (op == fsric_pkg::OP_RECAL);
  wire is_snsi = (op == fsric_pkg::OP_SNSI);
  wire is_snsd = (op == fsric_pkg::OP_SNSD);
  wire refuse = any_step & ~is_seek;
  wire miss_sns = pend & ~is_snsi;
  wire bad_op = ~(is_seek | is_recal | is_snsi | is_snsd);
  wire go_inv = wr_cmd & (bad_op | refuse | miss_sns);
  wire go_seek = wr_cmd & is_seek & ~miss_sns;
  wire go_recal = wr_cmd & is_recal & ~refuse & ~miss_sns;
  wire go_snsi = wr_cmd & is_snsi & ~refuse;
  wire go_snsd = wr_cmd & is_snsd & ~refuse & ~miss_sns;

  // sense interrupt source pick, seek ends before ready changes
  logic [1:0] pick;
  logic pick_end;
  always_comb begin
    pick = 2'd0;
    pick_end = 1'b0;
    for (int i = 3; i >= 0; i--) begin
      if (rchg_q[i]) begin
        pick = 2'(i);
      end
    end
    for (int i = 3; i >= 0; i--) begin
      if (endp_q[i]) begin
        pick = 2'(i);
        pick_end = 1'b1;
      end
    end
  end

  for (genvar d = 0; d < 4; d++) begin : g_drv
    wire dsel = (cdrv == 2'(d));
    assign seek_go[d] = go_seek & dsel;
    assign recal_go[d] = go_recal & dsel;
    assign sns_clr[d] = go_snsi & pend & (pick == 2'(d));
    assign stepping[d] = (st_q[d] != fsric_pkg::FSRIC_IDLE);
    assign step_o[d] = (st_q[d] == fsric_pkg::FSRIC_PULSE);
    assign dir_o[d] = dirq[d];
    always_ff @(posedge clk_i) begin
      rdy_p[d] <= rdy_s[d];
      if (rst_i) begin
        st_q[d] <= fsric_pkg::FSRIC_IDLE;
        pcn_q[d] <= '0;
        tgt_q[d] <= '0;
        code_q[d] <= '0;
        nstep_q[d] <= '0;
        pw_q[d] <= '0;
        iv_q[d] <= '0;
        recal_q[d] <= 1'b0;
        dirq[d] <= 1'b0;
        endp_q[d] <= 1'b0;
        busy_q[d] <= 1'b0;
        rchg_q[d] <= 1'b0;
      end else begin
        if (rdy_s[d] != rdy_p[d]) begin
          rchg_q[d] <= 1'b1;
        end else if (sns_clr[d] && !pick_end) begin
          rchg_q[d] <= 1'b0;
        end
        if (seek_go[d] || recal_go[d]) begin
          st_q[d] <= fsric_pkg::FSRIC_DEC;
          tgt_q[d] <= ctgt;
          recal_q[d] <= recal_go[d];
          nstep_q[d] <= '0;
          busy_q[d] <= 1'b1;
          endp_q[d] <= 1'b0;
          if (recal_go[d]) begin
            pcn_q[d] <= '0;
          end
        end else begin
          if (sns_clr[d] && pick_end) begin
            endp_q[d] <= 1'b0;
            busy_q[d] <= 1'b0;
          end
          unique case (st_q[d])
            fsric_pkg::FSRIC_IDLE: begin
            end
            fsric_pkg::FSRIC_DEC: begin
              if (!rdy_s[d]) begin
                st_q[d] <= fsric_pkg::FSRIC_IDLE;
                endp_q[d] <= 1'b1;
                code_q[d] <= fsric_pkg::ST0_NRDY | 8'(d);
              end else if (recal_q[d] && tz_s[d]) begin
                st_q[d] <= fsric_pkg::FSRIC_IDLE;
                endp_q[d] <= 1'b1;
                code_q[d] <= fsric_pkg::ST0_NORM | 8'(d);
              end else if (recal_q[d] &&
                           nstep_q[d] == fsric_pkg::RECAL_MAX) begin
                st_q[d] <= fsric_pkg::FSRIC_IDLE;
                endp_q[d] <= 1'b1;
                code_q[d] <= fsric_pkg::ST0_EC | 8'(d);
              end else if (recal_q[d]) begin
                dirq[d] <= 1'b0;
                nstep_q[d] <= nstep_q[d] + 7'h1;
                pw_q[d] <= 8'(fsric_pkg::STEP_PW_CYC - 1);
                st_q[d] <= fsric_pkg::FSRIC_PULSE;
              end else if (pcn_q[d] == tgt_q[d]) begin
                st_q[d] <= fsric_pkg::FSRIC_IDLE;
                endp_q[d] <= 1'b1;
                code_q[d] <= fsric_pkg::ST0_NORM | 8'(d);
              end else if (pcn_q[d] < tgt_q[d]) begin
                dirq[d] <= 1'b1;
                pcn_q[d] <= pcn_q[d] + 8'h1;
                pw_q[d] <= 8'(fsric_pkg::STEP_PW_CYC - 1);
                st_q[d] <= fsric_pkg::FSRIC_PULSE;
              end else begin
                dirq[d] <= 1'b0;
                pcn_q[d] <= pcn_q[d] - 8'h1;
                pw_q[d] <= 8'(fsric_pkg::STEP_PW_CYC - 1);
                st_q[d] <= fsric_pkg::FSRIC_PULSE;
              end
            end
            fsric_pkg::FSRIC_PULSE: begin
              if (pw_q[d] == 8'h0) begin
                iv_q[d] <= step_ms;
                st_q[d] <= fsric_pkg::FSRIC_WAIT;
              end else begin
                pw_q[d] <= pw_q[d] - 8'h1;
              end
            end
            fsric_pkg::FSRIC_WAIT: begin
              // first tick lands anywhere in the ms: gap up to 1 ms short
              if (iv_q[d] == 5'h0) begin
                st_q[d] <= fsric_pkg::FSRIC_DEC;
              end else if (ms_tick) begin
                iv_q[d] <= iv_q[d] - 5'h1;
              end
            end
          endcase
        end
      end
    end
  end

  // result phase, non-dma execution and their interrupts
  logic [7:0] res0_q, res1_q;
  logic dio_q, ndx_q, res_irq_q, nd_irq_q;
  wire [7:0] st3 = {1'b0, wp_s[cdrv], rdy_s[cdrv], tz_s[cdrv], 1'b0,
                    chead, cdrv};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res0_q <= '0;
      res1_q <= '0;
      dio_q <= 1'b0;
      ndx_q <= 1'b0;
      res_irq_q <= 1'b0;
      nd_irq_q <= 1'b0;
    end else begin
      if (go_inv || (go_snsi && !pend)) begin
        res0_q <= fsric_pkg::ST0_INV;
        res1_q <= '0;
        dio_q <= 1'b1;
      end else if (go_snsi) begin
        res0_q <= pick_end ? code_q[pick] :
                  (fsric_pkg::ST0_RCHG | {6'h0, pick});
        res1_q <= pcn_q[pick];
        dio_q <= 1'b1;
      end else if (go_snsd) begin
        res0_q <= st3;
        res1_q <= '0;
        dio_q <= 1'b1;
      end else if (rd_res) begin
        dio_q <= 1'b0;
      end
      if (result_enter_i) begin
        ndx_q <= 1'b0;
      end else if (exec_start_i && no_dma) begin
        ndx_q <= 1'b1;
      end
      if (result_enter_i) begin
        res_irq_q <= 1'b1;
      end else if (host_data_i) begin
        res_irq_q <= 1'b0;
      end
      if (byte_req_i && ndx_q) begin
        nd_irq_q <= 1'b1;
      end else if (host_data_i) begin
        nd_irq_q <= 1'b0;
      end
    end
  end

  // interrupt line: sense-cleared and data-cleared sources
  logic irq_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= pend | res_irq_q | nd_irq_q;
    end
  end
  assign irq_o = irq_q;

  // head load and unload timing
  fsric_pkg::fsric_head_t hd_q;
  logic [7:0] hcnt_q;
  wire [7:0] hlt_ms = (hlt_code == 7'h0) ? 8'hfe :
                      8'(hlt_code) * fsric_pkg::LOAD_STEP;
  wire [7:0] hut_ms = (hut_code == 4'h0) ? 8'hff :
                      8'(hut_code) * fsric_pkg::UNLD_STEP;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hd_q <= fsric_pkg::FSRIC_H_OFF;
      hcnt_q <= '0;
    end else begin
      unique case (hd_q)
        fsric_pkg::FSRIC_H_OFF: begin
          if (head_req_i) begin
            hd_q <= fsric_pkg::FSRIC_H_LOAD;
            hcnt_q <= hlt_ms;
          end
        end
        fsric_pkg::FSRIC_H_LOAD: begin
          if (hcnt_q == 8'h0) begin
            hd_q <= fsric_pkg::FSRIC_H_RDY;
          end else if (ms_tick) begin
            hcnt_q <= hcnt_q - 8'h1;
          end
        end
        fsric_pkg::FSRIC_H_RDY: begin
          if (rw_end_i) begin
            hd_q <= fsric_pkg::FSRIC_H_UNLD;
            hcnt_q <= hut_ms;
          end
        end
        fsric_pkg::FSRIC_H_UNLD: begin
          if (head_req_i) begin
            hd_q <= fsric_pkg::FSRIC_H_RDY;
          end else if (hcnt_q == 8'h0) begin
            hd_q <= fsric_pkg::FSRIC_H_OFF;
          end else if (ms_tick) begin
            hcnt_q <= hcnt_q - 8'h1;
          end
        end
      endcase
    end
  end
  assign head_load_o = (hd_q != fsric_pkg::FSRIC_H_OFF);
  assign head_ready_o = (hd_q == fsric_pkg::FSRIC_H_RDY);

  // main status: busy bits, non-dma exec, direction, request
  wire [7:0] msr = {1'b1, dio_q, ndx_q, 1'b0, busy_q};
  wire [31:0] pcn_all = {pcn_q[3], pcn_q[2], pcn_q[1], pcn_q[0]};
  wire [31:0] head_w = {30'h0, head_ready_o, head_load_o};
  logic [31:0] rd_mux;
  always_comb begin
    unique case (adr_i)
      fsric_pkg::A_SPEC: rd_mux = {16'h0, spec_q};
      fsric_pkg::A_MSR: rd_mux = {24'h0, msr};
      fsric_pkg::A_RES: rd_mux = {16'h0, res1_q, res0_q};
      fsric_pkg::A_PCN: rd_mux = pcn_all;
      fsric_pkg::A_HEAD: rd_mux = head_w;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_o <= '0;
      spec_q <= fsric_pkg::SPEC_RST;
    end else begin
      ack_q <= acc;
      if (rd) begin
        dat_o <= rd_mux;
      end
      if (wr_spec && sel_i[0]) begin
        spec_q[7:0] <= dat_i[7:0];
      end
      if (wr_spec && sel_i[1]) begin
        spec_q[15:8] <= dat_i[15:8];
      end
    end
  end
  assign ack_o = ack_q;
endmodule // fsric_top

// File: tb/fsric_drive_model.sv
// behavioural model of four drives on the step lines
`timescale 1ns/1ps
module fsric_drive_model (
  input wire logic clk_i,
  input wire logic [3:0] step_i,
  input wire logic [3:0] dir_i,
  input wire logic [3:0] stuck_i,
  input wire logic [3:0] ready_en_i,
  output logic [3:0] ready_o,
  output logic [3:0] track_zero_o,
  output logic [3:0] wprot_o
);
  logic [7:0] pos_q [4] = '{8'h02, 8'h02, 8'h02, 8'h02};
  logic [3:0] step_q = 4'h0;
  assign ready_o = ready_en_i;
  assign wprot_o = 4'h5;
  always @(posedge clk_i) begin
    step_q <= step_i;
    for (int k = 0; k < 4; k++) begin
      if (step_i[k] && !step_q[k]) begin
        if (dir_i[k]) begin
          pos_q[k] <= pos_q[k] + 8'h01;
        end else if (pos_q[k] != 8'h00) begin
          pos_q[k] <= pos_q[k] - 8'h01;
        end
      end
    end
  end
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      track_zero_o[k] = pos_q[k] == 8'h00 && !stuck_i[k];
    end
  end
endmodule // fsric_drive_model

// File: tb/fsric_monitor.sv
// port assertions for the positioning controller
`timescale 1ns/1ps
module fsric_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [3:0] step_o,
  input wire logic [3:0] dir_o,
  input wire logic head_load_o,
  input wire logic head_ready_o,
  input wire logic dma_mode_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = cyc_i && stb_i && !ack_o;
  wire spec_wr = req && we_i && adr_i == fsric_pkg::A_SPEC && sel_i[1];
  wire msr_rd = req && !we_i && adr_i == fsric_pkg::A_MSR;
  ack_follows_a: assert property (req |=> ack_o)
    else $error("no ack after request");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  request_bit_a: assert property ($past(msr_rd) |-> dat_o[7])
    else $error("request bit low in main status");
  step_width_a: assert property ($rose(step_o[0]) |->
    ##199 step_o[0] ##1 !step_o[0]) else $error("step pulse width wrong");
  dir_hold_a: assert property (step_o[1] && $past(step_o[1]) |->
    $stable(dir_o[1])) else $error("direction moved during step");
  dma_write_a: assert property (spec_wr |=>
    dma_mode_o == !$past(dat_i[15])) else $error("dma mode wrong");
  dma_cause_a: assert property ($changed(dma_mode_o) |->
    $past(spec_wr)) else $error("dma mode changed without write");
  head_order_a: assert property (head_ready_o |-> head_load_o)
    else $error("head ready without load");
  load_delay_a: assert property ($rose(head_load_o) |->
    !head_ready_o [*8]) else $error("head ready too early");
  cover property ($rose(step_o[0]));
  cover property ($rose(irq_o));
  cover property ($rose(head_ready_o));
endmodule // fsric_monitor

// File: tb/test_floppy_seek_recal_intr_ctrl.sv
// self-checking bench for the positioning controller
`timescale 1ns/1ps
module test_floppy_seek_recal_intr_ctrl;
  localparam int unsigned MSC = 20;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic ack_o, head_load_o, head_ready_o, dma_mode_o, irq_o;
  logic [5:0] ev = 6'h00;
  logic [3:0] stuck = 4'h0, rdy_en = 4'hf;
  logic [3:0] ready_i, track_zero_i, wprot_i, step_o, dir_o, ldir;
  logic [3:0] st_q = 4'h0;
  int n_step [4] = '{0, 0, 0, 0};
  int base [4];
  int n_fail = 0;
  int total_checks = 0;
  always #2.5 clk_i = !clk_i;
  fsric_top #(.MS_CYC(MSC)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .ready_i(ready_i), .track_zero_i(track_zero_i), .wprot_i(wprot_i),
    .result_enter_i(ev[0]), .exec_start_i(ev[1]), .byte_req_i(ev[2]),
    .host_data_i(ev[3]), .head_req_i(ev[4]), .rw_end_i(ev[5]),
    .step_o(step_o), .dir_o(dir_o), .head_load_o(head_load_o),
    .head_ready_o(head_ready_o), .dma_mode_o(dma_mode_o), .irq_o(irq_o));
  fsric_drive_model i_drv (.clk_i(clk_i), .step_i(step_o), .dir_i(dir_o),
    .stuck_i(stuck), .ready_en_i(rdy_en), .ready_o(ready_i),
    .track_zero_o(track_zero_i), .wprot_o(wprot_i));
  always @(posedge clk_i) begin
    st_q <= step_o;
    for (int k = 0; k < 4; k++) begin
      if (step_o[k] && !st_q[k]) begin
        n_step[k] <= n_step[k] + 1;
        ldir[k] <= dir_o[k];
      end
    end
  end
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    chk(n, {15'h0, e}, {15'h0, g});
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic cmd(input logic [2:0] op, input logic [1:0] dv,
                     input logic [7:0] cy);
    wb(1'b1, fsric_pkg::A_CMD, {16'h0000, cy, 2'b00, dv, 1'b0, op});
  endtask
  task automatic sns(input logic [15:0] e, input logic [15:0] m);
    cmd(fsric_pkg::OP_SNSI, 2'h0, 8'h00);
    rd(fsric_pkg::A_RES);
    chk("result", e, q[15:0] & m);
  endtask
  task automatic seek(input logic [2:0] op, input logic [1:0] dv,
                      input logic [7:0] cy);
    base = n_step;
    cmd(op, dv, cy);
    while (irq_o !== 1'b1) @(posedge clk_i);
  endtask
  task automatic steps(input int dv, input int n);
    chk("steps", 16'(n), 16'(n_step[dv] - base[dv]));
  endtask
  task automatic pulse(input logic [5:0] m);
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= 6'h00;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_i);
    n_fail++;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) sns(16'h0080, 16'hffff);
    chk1("dma", 1'b1, dma_mode_o);
    wb(1'b1, fsric_pkg::A_SPEC, 32'h0000811f);
    rd(fsric_pkg::A_SPEC);
    chk("spec", 16'h811f, q[15:0]);
    chk1("dma", 1'b0, dma_mode_o);
    pulse(6'h02);
    rd(fsric_pkg::A_MSR);
    chk1("exec bit", 1'b1, q[5]);
    pulse(6'h04);
    chk1("irq", 1'b1, irq_o);
    pulse(6'h08);
    chk1("irq", 1'b0, irq_o);
    pulse(6'h01);
    chk1("irq", 1'b1, irq_o);
    rd(fsric_pkg::A_MSR);
    chk1("exec bit", 1'b0, q[5]);
    pulse(6'h08);
    chk1("irq", 1'b0, irq_o);
    wb(1'b1, fsric_pkg::A_SPEC, 32'h0000011f);
    pulse(6'h10);
    repeat (12) @(posedge clk_i);
    chk1("head ready", 1'b0, head_ready_o);
    repeat (35) @(posedge clk_i);
    chk1("head ready", 1'b1, head_ready_o);
    pulse(6'h20);
    repeat (286) @(posedge clk_i);
    chk1("head load", 1'b1, head_load_o);
    repeat (50) @(posedge clk_i);
    chk1("head load", 1'b0, head_load_o);
    seek(fsric_pkg::OP_SEEK, 2'h0, 8'h03);
    steps(0, 3);
    steps(1, 0);
    chk1("dir", 1'b1, ldir[0]);
    rd(fsric_pkg::A_MSR);
    chk("busy", 16'h0001, {12'h0, q[3:0]});
    cmd(fsric_pkg::OP_SNSD, 2'h1, 8'h00);
    rd(fsric_pkg::A_RES);
    chk("result", 16'h0080, {8'h0, q[7:0]});
    sns(16'h0320, 16'hffff);
    chk1("irq", 1'b0, irq_o);
    rd(fsric_pkg::A_MSR);
    chk("busy", 16'h0000, {12'h0, q[3:0]});
    seek(fsric_pkg::OP_SEEK, 2'h0, 8'h01);
    steps(0, 2);
    chk1("dir", 1'b0, ldir[0]);
    sns(16'h0120, 16'hffff);
    base = n_step;
    cmd(fsric_pkg::OP_SEEK, 2'h1, 8'h02);
    cmd(fsric_pkg::OP_SEEK, 2'h2, 8'h01);
    cmd(fsric_pkg::OP_RECAL, 2'h3, 8'h00);
    rd(fsric_pkg::A_RES);
    chk("result", 16'h0080, {8'h0, q[7:0]});
    repeat (1500) @(posedge clk_i);
    steps(1, 2);
    steps(2, 1);
    sns(16'h0221, 16'hffff);
    sns(16'h0122, 16'hffff);
    sns(16'h0080, 16'h00ff);
    seek(fsric_pkg::OP_RECAL, 2'h0, 8'h00);
    steps(0, 3);
    chk1("dir", 1'b0, ldir[0]);
    sns(16'h0020, 16'hffff);
    rd(fsric_pkg::A_PCN);
    chk("cylinders", 16'h0200, q[15:0]);
    stuck <= 4'h8;
    seek(fsric_pkg::OP_RECAL, 2'h3, 8'h00);
    steps(3, 77);
    sns(16'h0073, 16'h00ff);
    stuck <= 4'h0;
    rdy_en <= 4'hb;
    while (irq_o !== 1'b1) @(posedge clk_i);
    sns(16'h00c2, 16'h00ff);
    cmd(fsric_pkg::OP_SNSD, 2'h0, 8'h00);
    rd(fsric_pkg::A_MSR);
    chk1("result wait", 1'b1, q[6]);
    chk1("irq", 1'b0, irq_o);
    rd(fsric_pkg::A_RES);
    chk("drive status", 16'h0070, q[15:0]);
    rd(fsric_pkg::A_MSR);
    chk1("result wait", 1'b0, q[6]);
    rd(8'h20);
    chk("unmapped", 16'h0000, q[15:0]);
    cmd(3'h7, 2'h0, 8'h00);
    rd(fsric_pkg::A_RES);
    chk("result", 16'h0080, q[15:0]);
    chk1("irq", 1'b0, irq_o);
    seek(fsric_pkg::OP_SEEK, 2'h2, 8'h05);
    steps(2, 0);
    sns(16'h016a, 16'hffff);
    tally_and_finish;
  end
endmodule // test_floppy_seek_recal_intr_ctrl
bind fsric_top fsric_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .step_o(step_o),
  .dir_o(dir_o), .head_load_o(head_load_o), .head_ready_o(head_ready_o),
  .dma_mode_o(dma_mode_o), .irq_o(irq_o));
